//--- verilog/imp_pkg.sv
// Package with register map, field layout and timing constants of the bank.
package imp_pkg;

  localparam int unsigned CLK_HZ = 40_000_000;

  // ****************************************************************
  // Register addresses (7-bit register index on the serial link)
  // ****************************************************************
  localparam logic [6:0] ADDR_IRQ_MASK = 7'h09;
  localparam logic [6:0] ADDR_PWM_CFG  = 7'h0A;
  localparam logic [6:0] ADDR_SCRATCH  = 7'h0B;

  // ****************************************************************
  // Reset values and writable-bit masks
  // ****************************************************************
  localparam logic [15:0] IRQ_MASK_RST = 16'h0140;
  localparam logic [15:0] IRQ_MASK_WR  = 16'h01FF;
  localparam logic [15:0] PWM_CFG_RST  = 16'h0000;
  localparam logic [15:0] PWM_CFG_WR   = 16'h7FF7;
  localparam logic [15:0] SCRATCH_RST  = 16'h0000;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned MB_PERIODIC  = 8;
  localparam int unsigned MB_WD_OFF    = 7;
  localparam int unsigned MB_WD_FAIL   = 6;
  localparam int unsigned MB_LINK_FAIL = 5;
  localparam int unsigned MB_BRIDGE    = 4;
  localparam int unsigned MB_HIGH_SIDE = 3;
  localparam int unsigned MB_BUS       = 2;
  localparam int unsigned MB_TEMP      = 1;
  localparam int unsigned MB_SUPPLY    = 0;
  localparam int unsigned PF_RATE      = 14;
  localparam int unsigned PF_DUTY_LO   = 4;
  localparam int unsigned PF_BANK_HI   = 2;
  localparam int unsigned DUTY_W       = 10;
  localparam int unsigned NUM_GEN      = 4;
  localparam logic [DUTY_W-1:0] DUTY_FULL = 10'h3FF;

  // ****************************************************************
  // Timing
  // ****************************************************************
  // One duty step is 1/1024 of the period; step rates for 100 and 200 Hz.
  localparam int unsigned PWM_SLOW_HZ = 100;
  localparam int unsigned PWM_FAST_HZ = 200;
  localparam int unsigned STEP_SLOW   = CLK_HZ / (PWM_SLOW_HZ * 1024);
  localparam int unsigned STEP_FAST   = CLK_HZ / (PWM_FAST_HZ * 1024);
  localparam int unsigned STEP_W      = 9;
  // Repeat interval of the periodic interrupt, in milliseconds.
  localparam int unsigned PERIODIC_MS = 10;
  localparam int unsigned PERIODIC_CYC = CLK_HZ / 1000 * PERIODIC_MS;
  localparam int unsigned INT_PULSE_US = 100;
  localparam int unsigned INT_PULSE_CYC = CLK_HZ / 1_000_000 * INT_PULSE_US;

  typedef struct packed {
    logic       wr;
    logic [6:0] addr;
    logic [15:0] data;
  } imp_req_t;

  typedef struct packed {
    logic bridge;
    logic high_side;
    logic bus;
    logic temp;
    logic supply;
  } imp_flags_t;

endpackage

//--- verilog/imp_regs.sv
// Interrupt mask, PWM generator configuration and host scratch registers.
//
// Notes on behaviour
// - Mask bits 15..9 read zero, ignore writes.
// - Bit 8 repeats interrupt while anything pending.
// - Bit 7 stops watchdog in development mode.
// - Bit 6 gates one watchdog-failure interrupt event, counted in development mode only.
// - Bit 5 gates link or checksum failure event.
// - Bits 4,3 gate bridge and high-side events.
// - Bits 2,1,0 gate bus, temperature, supply events.
// - Every new event pulses, even if already set.
// - Rate bit picks 100 Hz or 200 Hz.
// - Ten-bit duty; zero off, all ones on.
// - Bank field picks generator; codes 1xx ignored.
// - Output valid after one complete PWM period.
// - Scratch accessible only in normal mode.
// - Scratch cleared by reset, kept otherwise.
// - Device logic never reads or changes scratch.
`timescale 1ns/1ps
`default_nettype none
module imp_regs
  import imp_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire imp_req_t           req,
  input  wire logic               req_valid,
  output logic [15:0]             rd_data,
  input  wire logic               normal_mode,
  input  wire logic               devmode,
  input  wire logic               wd_fail,
  input  wire logic               link_fail,
  input  wire imp_flags_t         flags_set,
  input  wire logic               irq_pending,
  output logic                    watchdog_enable,
  output logic                    interrupt_output_n,
  output logic [NUM_GEN-1:0]      pwm_out,
  output logic [NUM_GEN-1:0]      pwm_valid
);

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [15:0] mask_q, mask_d;
  logic [15:0] cfg_q, cfg_d;
  logic [15:0] scratch_q, scratch_d;
  logic [DUTY_W-1:0] duty_q [NUM_GEN];
  logic [DUTY_W-1:0] duty_d [NUM_GEN];
  logic [NUM_GEN-1:0] fast_q, fast_d;
  logic [NUM_GEN-1:0] cfg_ev;

  function automatic logic hit(input imp_req_t r, input logic [6:0] a);
    return r.addr == a;
  endfunction

  always_comb begin
    mask_d    = mask_q;
    cfg_d     = cfg_q;
    scratch_d = scratch_q;
    fast_d    = fast_q;
    cfg_ev    = '0;
    for (int g = 0; g < NUM_GEN; g++) begin
      duty_d[g] = duty_q[g];
    end
    if (req_valid && req.wr) begin
      if (hit(req, ADDR_IRQ_MASK)) begin
        mask_d = req.data & IRQ_MASK_WR;
      end else if (hit(req, ADDR_PWM_CFG)) begin
        cfg_d = req.data & PWM_CFG_WR;
        // Codes 1xx store into the register but reach no generator.
        if (!req.data[PF_BANK_HI]) begin
          for (int g = 0; g < NUM_GEN; g++) begin
            if (req.data[PF_BANK_HI-1:0] == 2'(g)) begin
              duty_d[g] = req.data[PF_DUTY_LO +: DUTY_W];
              fast_d[g] = req.data[PF_RATE];
              cfg_ev[g] = 1'b1;
            end
          end
        end
      end else if (hit(req, ADDR_SCRATCH) && normal_mode) begin
        scratch_d = req.data;
      end
    end
  end

  // Only the host port and reset touch scratch; fail-safe does not.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mask_q    <= IRQ_MASK_RST;
      cfg_q     <= PWM_CFG_RST;
      scratch_q <= SCRATCH_RST;
      fast_q    <= '0;
      for (int g = 0; g < NUM_GEN; g++) begin
        duty_q[g] <= '0;
      end
    end else begin
      mask_q    <= mask_d;
      cfg_q     <= cfg_d;
      scratch_q <= scratch_d;
      fast_q    <= fast_d;
      for (int g = 0; g < NUM_GEN; g++) begin
        duty_q[g] <= duty_d[g];
      end
    end
  end

  logic [15:0] rd_d, rd_q;
  always_comb begin
    if (hit(req, ADDR_IRQ_MASK)) begin
      rd_d = mask_q;
    end else if (hit(req, ADDR_PWM_CFG)) begin
      rd_d = cfg_q;
    end else if (hit(req, ADDR_SCRATCH) && normal_mode) begin
      rd_d = scratch_q;
    end else begin
      rd_d = '0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_q <= '0;
    end else if (req_valid && !req.wr) begin
      rd_q <= rd_d;
    end
  end
  assign rd_data = rd_q;

  // ****************************************************************
  // Watchdog gating
  // ****************************************************************
  assign watchdog_enable = !(devmode && mask_q[MB_WD_OFF]);

  // ****************************************************************
  // Interrupt events and output pulse
  // ****************************************************************
  logic ev;
  logic [31:0] per_cnt_q, per_cnt_d;
  logic [31:0] pls_cnt_q, pls_cnt_d;
  logic        per_hit;
  logic        irq_n_q, irq_n_d;

  always_comb begin
    ev = (mask_q[MB_WD_FAIL] && wd_fail && devmode)
       | (mask_q[MB_LINK_FAIL] && link_fail)
       | (mask_q[MB_BRIDGE] && flags_set.bridge)
       | (mask_q[MB_HIGH_SIDE] && flags_set.high_side)
       | (mask_q[MB_BUS] && flags_set.bus)
       | (mask_q[MB_TEMP] && flags_set.temp)
       | (mask_q[MB_SUPPLY] && flags_set.supply);
    per_hit = 1'b0;
    per_cnt_d = '0;
    if (mask_q[MB_PERIODIC] && irq_pending) begin
      if (per_cnt_q == 32'(PERIODIC_CYC - 1)) begin
        per_hit = 1'b1;
      end else begin
        per_cnt_d = per_cnt_q + 32'h1;
      end
    end
    // A fresh event restarts the pulse, so none is swallowed.
    if (ev || per_hit) begin
      pls_cnt_d = 32'(INT_PULSE_CYC);
    end else if (pls_cnt_q != '0) begin
      pls_cnt_d = pls_cnt_q - 32'h1;
    end else begin
      pls_cnt_d = '0;
    end
    // The pin comes straight from a flip-flop so a counter carry cannot glitch it.
    irq_n_d = (pls_cnt_d == '0);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      per_cnt_q <= '0;
      pls_cnt_q <= '0;
      irq_n_q   <= 1'b1;
    end else begin
      per_cnt_q <= per_cnt_d;
      pls_cnt_q <= pls_cnt_d;
      irq_n_q   <= irq_n_d;
    end
  end
  assign interrupt_output_n = irq_n_q;

  // ****************************************************************
  // PWM generators
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_GEN; gi++) begin : g_pwm
      logic [STEP_W-1:0] pre_q, pre_d;
      logic [DUTY_W-1:0] cnt_q, cnt_d;
      logic              out_q, out_d;
      logic              val_q, val_d;
      logic              seen_q, seen_d;
      logic              tick;
      always_comb begin
        tick  = pre_q == (fast_q[gi] ? STEP_W'(STEP_FAST - 1)
                                     : STEP_W'(STEP_SLOW - 1));
        pre_d = tick ? '0 : pre_q + STEP_W'(1);
        cnt_d = tick ? cnt_q + DUTY_W'(1) : cnt_q;
        // Full scale holds the output on; count 1023 would drop it.
        out_d = (duty_q[gi] == DUTY_FULL) || (cnt_q < duty_q[gi]);
        seen_d = seen_q;
        val_d  = val_q;
        if (cfg_ev[gi]) begin
          seen_d = 1'b0;
          val_d  = 1'b0;
        end else if (tick && cnt_q == DUTY_FULL) begin
          // Valid after the first full period that starts after wrap.
          if (seen_q) begin
            val_d = 1'b1;
          end
          seen_d = 1'b1;
        end
      end
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          pre_q  <= '0;
          cnt_q  <= '0;
          out_q  <= 1'b0;
          val_q  <= 1'b0;
          seen_q <= 1'b0;
        end else begin
          pre_q  <= pre_d;
          cnt_q  <= cnt_d;
          out_q  <= out_d;
          val_q  <= val_d;
          seen_q <= seen_d;
        end
      end
      assign pwm_out[gi]   = out_q;
      assign pwm_valid[gi] = val_q;
    end
  endgenerate

endmodule
`default_nettype wire

//--- testbench/imp_regs_asserts.sv
// Port checker for the interrupt mask, PWM and scratch register bank.
`timescale 1ns/1ps
`default_nettype none
module imp_regs_asserts
  import imp_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire imp_req_t           req,
  input  wire logic               req_valid,
  input  wire logic [15:0]        rd_data,
  input  wire logic               normal_mode,
  input  wire logic               devmode,
  input  wire logic               wd_fail,
  input  wire logic               link_fail,
  input  wire imp_flags_t         flags_set,
  input  wire logic               irq_pending,
  input  wire logic               watchdog_enable,
  input  wire logic               interrupt_output_n,
  input  wire logic [NUM_GEN-1:0] pwm_out,
  input  wire logic [NUM_GEN-1:0] pwm_valid
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic [15:0]        mask_q;
  logic [NUM_GEN-1:0] zero_q;
  logic [NUM_GEN-1:0] full_q;
  logic               rd_go;
  logic               pwm_wr;
  logic               evt;
  assign rd_go = req_valid && !req.wr;
  assign pwm_wr = req_valid && req.wr && req.addr == ADDR_PWM_CFG;
  // Any cause that may legally pull the interrupt low at the next edge.
  assign evt = |(flags_set & mask_q[4:0]) || (link_fail && mask_q[5]) ||
               (wd_fail && devmode && mask_q[6]) || (irq_pending && mask_q[8]);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mask_q <= IRQ_MASK_RST;
      zero_q <= '1;
      full_q <= '0;
    end else begin
      if (req_valid && req.wr && req.addr == ADDR_IRQ_MASK) begin
        mask_q <= req.data;
      end
      if (pwm_wr && !req.data[2]) begin
        zero_q[req.data[1:0]] <= req.data[13:4] == '0;
        full_q[req.data[1:0]] <= req.data[13:4] == DUTY_FULL;
      end
    end
  end
  AST_MASK_RSVD: assert property (
    rd_go && req.addr == ADDR_IRQ_MASK |=> rd_data[15:9] == 7'h00)
    else $error("mask reserved bits not zero");
  AST_PWM_RSVD: assert property (
    rd_go && req.addr == ADDR_PWM_CFG |=> !rd_data[15] && !rd_data[3])
    else $error("pwm reserved bits set");
  AST_SCR_LOCK: assert property (
    rd_go && req.addr == ADDR_SCRATCH && !normal_mode
    |=> rd_data == 16'h0000) else $error("scratch readable");
  AST_WD_SEL: assert property (
    devmode |-> watchdog_enable == !mask_q[7])
    else $error("watchdog enable wrong");
  AST_FLAG_EVT: assert property (
    |(flags_set & mask_q[4:0]) |=> !interrupt_output_n)
    else $error("flag event lost");
  AST_LINK_EVT: assert property (
    link_fail && mask_q[5] |=> !interrupt_output_n)
    else $error("link failure event lost");
  AST_WD_EVT: assert property (
    wd_fail && devmode && mask_q[6] |=> !interrupt_output_n)
    else $error("watchdog event lost");
  AST_NO_EVT: assert property (
    interrupt_output_n && !evt |=> interrupt_output_n)
    else $error("interrupt without event");
  AST_PULSE: assert property (
    $fell(interrupt_output_n) |-> !interrupt_output_n [*8])
    else $error("interrupt pulse too short");
  AST_DUTY_ENDS: assert property (
    !pwm_wr [*4] |-> !(|(pwm_out & zero_q)) && &(pwm_out | ~full_q))
    else $error("pwm output ignores duty end value");
endmodule
bind imp_regs imp_regs_asserts i_imp_regs_asserts (.clock(clock), .rst(rst),
  .req(req), .req_valid(req_valid), .rd_data(rd_data),
  .normal_mode(normal_mode), .devmode(devmode), .wd_fail(wd_fail),
  .link_fail(link_fail), .flags_set(flags_set), .irq_pending(irq_pending),
  .watchdog_enable(watchdog_enable), .interrupt_output_n(interrupt_output_n),
  .pwm_out(pwm_out), .pwm_valid(pwm_valid));
`default_nettype wire

//--- testbench/imp_host_model.sv
// Host model that issues register accesses to the bank.
`timescale 1ns/1ps
`default_nettype none
module imp_host_model
  import imp_pkg::*;
(
  input  wire logic        clock,
  input  wire logic [15:0] rd_data,
  output imp_req_t         req,
  output logic             req_valid
);
  initial begin
    req = '0;
    req_valid = 1'b0;
  end
  // Released fields carry the inverse so stale values never look valid.
  task automatic access(input logic wr, input logic [6:0] addr,
                        input logic [15:0] data, output logic [15:0] rdat);
    @(posedge clock);
    req <= '{wr: wr, addr: addr, data: data};
    req_valid <= 1'b1;
    @(posedge clock);
    req <= ~req;
    req_valid <= 1'b0;
    // Read data is registered and stands from the taking edge to the next read.
    @(posedge clock);
    rdat = rd_data;
  endtask
endmodule
`default_nettype wire

//--- testbench/test_irq_mask_pwm_scratch_regs.sv
// Self-checking bench of the interrupt mask, PWM and scratch registers.
`timescale 1ns/1ps
`default_nettype none
module test_irq_mask_pwm_scratch_regs
  import imp_pkg::*;
;
  logic               clock = 1'b0;
  logic               rst = 1'b1;
  logic               normal_mode = 1'b1;
  logic               devmode = 1'b1;
  logic               irq_pending = 1'b0;
  logic [6:0]         ev = '0;
  logic [15:0]        rd_data;
  logic [15:0]        got;
  logic [15:0]        d;
  logic [6:0]         a;
  logic               irq_n;
  logic               wd_en;
  logic [NUM_GEN-1:0] pwm_out;
  logic [NUM_GEN-1:0] pwm_valid;
  imp_req_t           req;
  logic               req_valid;
  logic [31:0]        seed = 32'h0000_1E45;
  int                 failures = 0;
  int                 samples_checked = 0;
  always #12.5 clock = ~clock;
  imp_regs i_imp_regs (.clock(clock), .rst(rst), .req(req),
    .req_valid(req_valid), .rd_data(rd_data), .normal_mode(normal_mode),
    .devmode(devmode), .wd_fail(ev[6]), .link_fail(ev[5]),
    .flags_set(ev[4:0]), .irq_pending(irq_pending), .watchdog_enable(wd_en),
    .interrupt_output_n(irq_n), .pwm_out(pwm_out), .pwm_valid(pwm_valid));
  imp_host_model i_imp_host_model (.clock(clock), .rd_data(rd_data),
    .req(req), .req_valid(req_valid));
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] kept(input logic [6:0] ad,
                                       input logic [15:0] dv);
    case (ad)
      ADDR_IRQ_MASK: return dv & IRQ_MASK_WR;
      ADDR_PWM_CFG: return dv & PWM_CFG_WR;
      ADDR_SCRATCH: return dv;
      default: return 16'h0000;
    endcase
  endfunction
  task automatic wr(input logic [6:0] ad, input logic [15:0] dv);
    i_imp_host_model.access(1'b1, ad, dv, got);
  endtask
  task automatic rd_chk(input logic [6:0] ad, input logic [15:0] exp);
    i_imp_host_model.access(1'b0, ad, 16'h0000, got);
    check("read data", exp, got);
  endtask
  // Masked runs write every other mask bit so only the source under test is off.
  // A watchdog failure only counts while development mode is on.
  task automatic fire(input int b, input logic on);
    int   n;
    logic expect_pulse;
    expect_pulse = on && (b != MB_WD_FAIL || devmode);
    wr(ADDR_IRQ_MASK, on ? 16'h0001 << b : 16'hFFFF ^ (16'h0001 << b));
    @(posedge clock);
    ev <= 7'h01 << b;
    @(posedge clock);
    ev <= '0;
    n = 0;
    repeat (INT_PULSE_CYC + 9) begin
      #1;
      if (irq_n === 1'b1) break;
      n++;
      @(posedge clock);
    end
    check("irq low cycles", expect_pulse ? 16'(INT_PULSE_CYC) : 16'h0000,
          16'(n));
    if (n > INT_PULSE_CYC) report_and_stop();
  endtask
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    rd_chk(ADDR_IRQ_MASK, IRQ_MASK_RST);
    rd_chk(ADDR_PWM_CFG, PWM_CFG_RST);
    rd_chk(ADDR_SCRATCH, SCRATCH_RST);
    for (int i = 0; i < 24; i++) begin
      a = 7'h09 + 7'(i % 4);
      d = (i < 4) ? 16'hFFFF : 16'(rnd());
      wr(a, d);
      rd_chk(a, kept(a, d));
    end
    wr(ADDR_IRQ_MASK, 16'h0080);
    check("watchdog enable", 16'h0000, {15'h0, wd_en});
    wr(ADDR_SCRATCH, 16'hA5C3);
    @(posedge clock) normal_mode <= 1'b0;
    rd_chk(ADDR_SCRATCH, 16'h0000);
    wr(ADDR_SCRATCH, 16'h1234);
    fire(0, 1'b1);
    @(posedge clock) normal_mode <= 1'b1;
    rd_chk(ADDR_SCRATCH, 16'hA5C3);
    check("watchdog enable", 16'h0001, {15'h0, wd_en});
    fire(0, 1'b1);
    // Pending interrupts must add no pulses; only masked runs set the repeat bit, and none lasts 10 ms.
    @(posedge clock) irq_pending <= 1'b1;
    for (int b = 0; b < 7; b++) begin
      fire(b, 1'b1);
      fire(b, 1'b0);
    end
    @(posedge clock) irq_pending <= 1'b0;
    @(posedge clock) devmode <= 1'b0;
    wr(ADDR_IRQ_MASK, 16'h0080);
    check("watchdog enable", 16'h0001, {15'h0, wd_en});
    fire(6, 1'b1);
    @(posedge clock) devmode <= 1'b1;
    wr(ADDR_PWM_CFG, 16'h3FF0);
    wr(ADDR_PWM_CFG, 16'h0001);
    wr(ADDR_PWM_CFG, 16'h0004);
    check("pwm valid", 16'h0000, {12'h000, pwm_valid});
    repeat (8) @(posedge clock);
    check("pwm out", 16'h0001, {12'h0, pwm_out} & 16'h0003);
    report_and_stop();
  end
endmodule
`default_nettype wire
